// >>> core/sgcr_channel.sv
/*
 * one channel's control register: stored bits, self-clearing pulses and the
 * read word with its fixed bits.
 * assumes the top decodes address and channel and gives a one-cycle write.
 */
`include "sgcr_params.svh"

module sgcr_channel #(
   parameter bit HAS_POWER_DOWN = 1'b0
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // write from the decoder
   input wire logic wr_en,
   input wire logic [15:0] wdata,
   // read word and control outputs
   output logic [15:0] ctrl_word,
   output sgcr_pkg::sgcr_ctrl_s chan_ctrl
);

   // stored bits and their next values
   logic rst_r, rst_nxt;
   logic spare14_r, spare14_nxt;
   logic an_en_r, an_en_nxt;
   logic bit11_r, bit11_nxt;
   logic iso_r, iso_nxt;
   logic restart_r, restart_nxt;
   logic unidir_r, unidir_nxt;

   // next-value logic of the register
   always_comb begin
      rst_nxt = 1'b0;
      restart_nxt = 1'b0;
      spare14_nxt = spare14_r;
      an_en_nxt = an_en_r;
      bit11_nxt = bit11_r;
      iso_nxt = iso_r;
      unidir_nxt = unidir_r;
      if (rst_r) begin
         // module reset taken: back to defaults, pulse ends
         spare14_nxt = `SGCR_RST_ZERO;
         an_en_nxt = `SGCR_RST_AN_ENABLE;
         bit11_nxt = `SGCR_RST_ZERO;
         iso_nxt = `SGCR_RST_ISOLATE;
         unidir_nxt = `SGCR_RST_ZERO;
      end else if (wr_en) begin
         rst_nxt = wdata[`SGCR_BIT_RESET];
         spare14_nxt = wdata[`SGCR_BIT_SPARE14];
         an_en_nxt = wdata[`SGCR_BIT_AN_ENABLE];
         if (HAS_POWER_DOWN) begin
            // only set by a write, cleared only by module reset
            bit11_nxt = bit11_r | wdata[`SGCR_BIT_POWER_DOWN];
         end else begin
            bit11_nxt = wdata[`SGCR_BIT_POWER_DOWN];
         end
         iso_nxt = wdata[`SGCR_BIT_ISOLATE];
         restart_nxt = wdata[`SGCR_BIT_AN_RESTART];
         unidir_nxt = wdata[`SGCR_BIT_UNIDIR];
      end
   end

   // register stage
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rst_r <= `SGCR_RST_ZERO;
         spare14_r <= `SGCR_RST_ZERO;
         an_en_r <= `SGCR_RST_AN_ENABLE;
         bit11_r <= `SGCR_RST_ZERO;
         iso_r <= `SGCR_RST_ISOLATE;
         restart_r <= `SGCR_RST_ZERO;
         unidir_r <= `SGCR_RST_ZERO;
      end else begin
         rst_r <= rst_nxt;
         spare14_r <= spare14_nxt;
         an_en_r <= an_en_nxt;
         bit11_r <= bit11_nxt;
         iso_r <= iso_nxt;
         restart_r <= restart_nxt;
         unidir_r <= unidir_nxt;
      end
   end

   // read word: fixed bits are constants, low five bits zero
   always_comb begin
      ctrl_word = 16'h0000;
      ctrl_word[`SGCR_BIT_RESET] = rst_r;
      ctrl_word[`SGCR_BIT_SPARE14] = spare14_r;
      ctrl_word[`SGCR_BIT_SPEED_LSB] = 1'b0;
      ctrl_word[`SGCR_BIT_AN_ENABLE] = an_en_r;
      ctrl_word[`SGCR_BIT_POWER_DOWN] = bit11_r;
      ctrl_word[`SGCR_BIT_ISOLATE] = iso_r;
      ctrl_word[`SGCR_BIT_AN_RESTART] = restart_r;
      ctrl_word[`SGCR_BIT_DUPLEX] = 1'b1;
      ctrl_word[`SGCR_BIT_COL_TEST] = 1'b0;
      ctrl_word[`SGCR_BIT_SPEED_MSB] = 1'b1;
      ctrl_word[`SGCR_BIT_UNIDIR] = unidir_r;
   end

   // control outputs toward the sgmii module
   always_comb begin
      chan_ctrl.module_reset = rst_r;
      chan_ctrl.an_enable = an_en_r;
      chan_ctrl.an_restart = restart_r;
      chan_ctrl.isolate = iso_r;
      chan_ctrl.power_down = HAS_POWER_DOWN ? bit11_r : 1'b0;
      chan_ctrl.unidir_tx = unidir_r & ~an_en_r;
   end

endmodule : sgcr_channel

// >>> core/sgcr_params.svh
/*
 * constants of the per-channel sgmii control register: address, bit
 * positions, reset word and channel count.
 * assumes it is included by bare name wherever these values are needed.
 */
`ifndef SGCR_PARAMS_SVH
`define SGCR_PARAMS_SVH

// management register address of the control register
`define SGCR_ADDR_CONTROL 5'h00
// number of sgmii modules sharing the management port
`define SGCR_NUM_CHAN 4

// bit positions inside the control word
`define SGCR_BIT_RESET 15
`define SGCR_BIT_SPARE14 14
`define SGCR_BIT_SPEED_LSB 13
`define SGCR_BIT_AN_ENABLE 12
`define SGCR_BIT_POWER_DOWN 11
`define SGCR_BIT_ISOLATE 10
`define SGCR_BIT_AN_RESTART 9
`define SGCR_BIT_DUPLEX 8
`define SGCR_BIT_COL_TEST 7
`define SGCR_BIT_SPEED_MSB 6
`define SGCR_BIT_UNIDIR 5

// reset values of the stored bits
`define SGCR_RST_AN_ENABLE 1'h1
`define SGCR_RST_ISOLATE 1'h1
`define SGCR_RST_ZERO 1'h0
// full control word as read right after reset
`define SGCR_CTRL_RESET_WORD 16'h1540

`endif

// >>> core/sgcr_pkg.sv
/*
 * types of the sgmii control register block: the management request and
 * the per-channel control outputs.
 * assumes sgcr_params.svh is compiled alongside.
 */
package sgcr_pkg;

   // one management access as presented on the register port
   typedef struct packed {
      logic wr;          // 1 = write, 0 = read
      logic [1:0] chan;  // sgmii module selected
      logic [4:0] addr;  // management register address
      logic [15:0] wdata; // write data
   } sgcr_mgmt_s;

   // control outputs of one channel toward its sgmii module
   typedef struct packed {
      logic module_reset; // one-cycle module reset pulse
      logic an_enable;    // auto-negotiation enabled
      logic an_restart;   // one-cycle auto-negotiation restart pulse
      logic isolate;      // isolate sgmii logic from gmii
      logic power_down;   // transceiver low-power (channel 0 only)
      logic unidir_tx;    // transmit without a valid link
   } sgcr_ctrl_s;

endpackage : sgcr_pkg

// >>> core/sgcr_top.sv
/*
 * management register bank of the four sgmii channels: control register at
 * address 0 per channel, zero for every other address.
 * assumes a decoded management port from the serial management interface,
 * one request per cycle at most, synchronous to sys_clk.
 */
`include "sgcr_params.svh"

module sgcr_top #(
   parameter int NUM_CHAN = `SGCR_NUM_CHAN
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // management request port
   input wire logic mgmt_req,
   input wire sgcr_pkg::sgcr_mgmt_s mgmt,
   // management answer
   output logic mgmt_ack,
   output logic [15:0] mgmt_rdata,
   // per-channel control toward the sgmii modules
   output sgcr_pkg::sgcr_ctrl_s [NUM_CHAN-1:0] chan_ctrl
);

   // address hit on the control register
   logic hit;
   // per-channel write strobes and read words
   logic [NUM_CHAN-1:0] chan_wr;
   logic [15:0] chan_word [NUM_CHAN];
   // answer registers
   logic ack_r, ack_nxt;
   logic [15:0] rdata_r, rdata_nxt;

   // address and channel decode
   always_comb begin
      hit = (mgmt.addr == `SGCR_ADDR_CONTROL);
      for (int i = 0; i < NUM_CHAN; i++) begin
         chan_wr[i] = mgmt_req & mgmt.wr & hit & (int'(mgmt.chan) == i);
      end
   end

   // one register copy per channel, only channel 0 has power-down
   for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
      sgcr_channel #(
         .HAS_POWER_DOWN(g == 0)
      ) u_chan (
         .sys_clk(sys_clk),
         .reset(reset),
         .wr_en(chan_wr[g]),
         .wdata(mgmt.wdata),
         .ctrl_word(chan_word[g]),
         .chan_ctrl(chan_ctrl[g])
      );
   end

   // answer: acknowledge every request, read data for reads
   always_comb begin
      ack_nxt = mgmt_req;
      rdata_nxt = rdata_r;
      if (mgmt_req && !mgmt.wr) begin
         // undefined address reads zero
         rdata_nxt = hit ? chan_word[mgmt.chan] : 16'h0000;
      end
   end

   // answer register stage
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ack_r <= 1'b0;
         rdata_r <= 16'h0000;
      end else begin
         ack_r <= ack_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // outputs straight from the answer registers
   assign mgmt_ack = ack_r;
   assign mgmt_rdata = rdata_r;

   // checks shared by all properties below
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   // undefined address reads answer zero one cycle later
   property p_undef_zero;
      (mgmt_req && !mgmt.wr && !hit) |=> (mgmt_ack && mgmt_rdata == 16'h0000);
   endproperty
   a_undef_zero: assert property (p_undef_zero)
      else $error("undefined address did not read zero");

   // every access is answered one cycle later, undefined addresses too
   property p_ack;
      mgmt_ack == $past(mgmt_req);
   endproperty
   a_ack: assert property (p_ack)
      else $error("acknowledge does not follow request");

   // power-down holds until a module reset
   property p_pd_hold;
      (chan_ctrl[0].power_down && !chan_ctrl[0].module_reset) |=> chan_ctrl[0].power_down;
   endproperty
   a_pd_hold: assert property (p_pd_hold)
      else $error("power-down cleared without module reset");

   // writing 1 to bit 11 of channel 0 powers down next cycle
   property p_pd_set;
      (chan_wr[0] && mgmt.wdata[11] && !chan_ctrl[0].module_reset)
         |=> chan_ctrl[0].power_down;
   endproperty
   a_pd_set: assert property (p_pd_set)
      else $error("power-down not set by write");

   // a channel 0 write never touches channel 1
   property p_chan_indep;
      (chan_wr[0] && !chan_wr[1] && !chan_ctrl[1].module_reset && !chan_ctrl[1].an_restart)
         |=> $stable(chan_word[1]);
   endproperty
   a_chan_indep: assert property (p_chan_indep)
      else $error("write leaked into another channel");

   // per-channel checks
   for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chk
      // reset pulse lasts one cycle then word is back to defaults
      property p_reset_pulse;
         (chan_wr[c] && mgmt.wdata[15] && !chan_ctrl[c].module_reset)
            |=> chan_ctrl[c].module_reset ##1 (!chan_ctrl[c].module_reset
            && chan_word[c] == `SGCR_CTRL_RESET_WORD);
      endproperty
      a_reset_pulse: assert property (p_reset_pulse)
         else $error("module reset pulse wrong");

      // restart pulse lasts one cycle unless a second restart is written
      property p_restart;
         (chan_wr[c] && mgmt.wdata[9] && !chan_ctrl[c].module_reset)
            |=> chan_ctrl[c].an_restart ##1 (chan_ctrl[c].an_restart
            == $past(chan_wr[c] && mgmt.wdata[9] && !chan_ctrl[c].module_reset));
      endproperty
      a_restart: assert property (p_restart)
         else $error("restart pulse wrong");

      // fixed bits never move
      property p_fixed;
         chan_word[c][13] == 1'b0 && chan_word[c][6] == 1'b1 && chan_word[c][8]
            && !chan_word[c][7] && chan_word[c][4:0] == 5'h00;
      endproperty
      a_fixed: assert property (p_fixed)
         else $error("fixed bits wrong");

      // stored bits 14, 12 and 10 follow the written value
      property p_store;
         (chan_wr[c] && !chan_ctrl[c].module_reset) |=>
            (chan_word[c][14] == $past(mgmt.wdata[14])
            && chan_ctrl[c].an_enable == $past(mgmt.wdata[12])
            && chan_ctrl[c].isolate == $past(mgmt.wdata[10]));
      endproperty
      a_store: assert property (p_store)
         else $error("stored bits do not follow write");

      // unconditional transmit only with negotiation off
      property p_unidir;
         chan_ctrl[c].unidir_tx == (chan_word[c][5] && !chan_word[c][12]);
      endproperty
      a_unidir: assert property (p_unidir)
         else $error("unidirectional transmit wrong");

      // isolate output matches bit 10
      property p_isolate;
         chan_ctrl[c].isolate == chan_word[c][10];
      endproperty
      a_isolate: assert property (p_isolate)
         else $error("isolate output mismatch");

      // a read of the control register returns this channel's own word
      property p_read_word;
         (mgmt_req && !mgmt.wr && hit && int'(mgmt.chan) == c)
            |=> (mgmt_rdata == $past(chan_word[c]));
      endproperty
      a_read_word: assert property (p_read_word)
         else $error("read word not from selected channel");

      // a write to an undefined address leaves the word alone
      property p_undef_write;
         (mgmt_req && mgmt.wr && !hit && !chan_ctrl[c].module_reset
            && !chan_ctrl[c].an_restart) |=> $stable(chan_word[c]);
      endproperty
      a_undef_write: assert property (p_undef_write)
         else $error("undefined address write changed a channel");

      // pulses drop on their own without a further write
      property p_self_clear;
         !chan_wr[c] |=> (!chan_ctrl[c].an_restart && !chan_ctrl[c].module_reset);
      endproperty
      a_self_clear: assert property (p_self_clear)
         else $error("self-clearing bit did not clear");

      // only channel 0 ever powers its transceiver down
      property p_pd_only0;
         (c == 0) || !chan_ctrl[c].power_down;
      endproperty
      a_pd_only0: assert property (p_pd_only0)
         else $error("power-down on a channel without it");
   end

   // main scenarios
   c_pd_cycle: cover property (chan_ctrl[0].power_down ##[1:20] !chan_ctrl[0].power_down);
   c_restart: cover property (chan_ctrl[1].an_restart);
   c_read_ctrl: cover property (mgmt_req && !mgmt.wr && hit ##1 mgmt_ack);
   c_unidir: cover property (chan_ctrl[2].unidir_tx);
   c_mod_reset: cover property (chan_ctrl[2].module_reset ##1 !chan_ctrl[2].module_reset);

endmodule : sgcr_top

// >>> testbench/sgcr_mgmt_master.sv
/*
 * station management master model: one register access per call on the
 * parallel management port of the control register bank.
 * assumes sgcr_pkg is compiled first and sys_clk runs freely.
 */
module sgcr_mgmt_master (
   // clock
   input wire logic sys_clk,
   // answer from the register bank
   input wire logic mgmt_ack,
   input wire logic [15:0] mgmt_rdata,
   // request toward the register bank
   output logic mgmt_req,
   output sgcr_pkg::sgcr_mgmt_s mgmt
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle port from time zero
   initial begin
      mgmt_req = 1'b0;
      mgmt = '0;
   end

   // raise just after an edge, hold through the taking edge, then release
   task automatic access(input logic wr, input logic [1:0] chan,
      input logic [4:0] addr, input logic [15:0] wdata,
      output logic ack, output logic [15:0] rdata);
      @(posedge sys_clk);
      #1;
      mgmt_req = 1'b1;
      mgmt = '{wr: wr, chan: chan, addr: addr, wdata: wdata};
      @(posedge sys_clk);
      #1;
      // answer stands for the one cycle after the taking edge
      ack = mgmt_ack;
      rdata = mgmt_rdata;
      mgmt_req = 1'b0;
      // released fields no longer show the last value
      mgmt = ~mgmt;
   endtask : access
endmodule : sgcr_mgmt_master

// >>> testbench/sgmii_channel_control_reg_tb.sv
/*
 * self-checking bench of the sgmii control register bank.
 * assumes sgcr_pkg, sgcr_top and the master model are compiled first.
 */
module sgmii_channel_control_reg_tb;
   timeunit 1ns;
   timeprecision 100ps;

   // clock, reset and wiring
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic mgmt_req;
   sgcr_pkg::sgcr_mgmt_s mgmt;
   logic mgmt_ack;
   logic [15:0] mgmt_rdata;
   sgcr_pkg::sgcr_ctrl_s [3:0] chan_ctrl;
   // counters and answer holders
   int n_mismatch = 0;
   int total_checks = 0;
   int cycles = 0;
   logic ack;
   logic [15:0] rd;

   // 125 MHz clock
   always #4 sys_clk = ~sys_clk;

   sgcr_top #(.NUM_CHAN(4)) u_dut (
      .sys_clk(sys_clk), .reset(reset), .mgmt_req(mgmt_req), .mgmt(mgmt),
      .mgmt_ack(mgmt_ack), .mgmt_rdata(mgmt_rdata), .chan_ctrl(chan_ctrl));

   sgcr_mgmt_master u_mgmt (
      .sys_clk(sys_clk), .mgmt_ack(mgmt_ack), .mgmt_rdata(mgmt_rdata),
      .mgmt_req(mgmt_req), .mgmt(mgmt));

   // verdict and end of run
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict

   // hang guard, far above the run length
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         $display("timeout after %0d cycles", cycles);
         give_verdict();
      end
   end

   // word compare
   task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk16

   // bit compare
   task automatic chk1(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask : chk1

   // write access, acked one cycle after taking
   task automatic wr(input logic [1:0] ch, input logic [4:0] a, input logic [15:0] d);
      u_mgmt.access(1'b1, ch, a, d, ack, rd);
      chk1("write ack", 1'b1, ack);
   endtask : wr

   // read access and word compare
   task automatic rdchk(input logic [1:0] ch, input logic [4:0] a, input logic [15:0] e);
      u_mgmt.access(1'b0, ch, a, 16'h0000, ack, rd);
      chk1("read ack", 1'b1, ack);
      chk16("read word", e, rd);
   endtask : rdchk

   // level outputs of one channel
   task automatic chk_lvl(input int ch, input logic an, iso, pd, uni);
      chk1("an_enable", an, chan_ctrl[ch].an_enable);
      chk1("isolate", iso, chan_ctrl[ch].isolate);
      chk1("power_down", pd, chan_ctrl[ch].power_down);
      chk1("unidir_tx", uni, chan_ctrl[ch].unidir_tx);
   endtask : chk_lvl

   // every channel starts at its reset word, isolated, negotiation on
   task automatic t_defaults();
      for (int ch = 0; ch < 4; ch++) begin
         rdchk(ch[1:0], 5'h00, 16'h1540);
         chk_lvl(ch, 1'b1, 1'b1, 1'b0, 1'b0);
      end
   endtask : t_defaults

   // stored and fixed bits on channel 1, channel 0 untouched
   task automatic t_store();
      wr(2'h1, 5'h00, 16'h7DFF);
      chk_lvl(1, 1'b1, 1'b1, 1'b0, 1'b0);
      rdchk(2'h1, 5'h00, 16'h5D60);
      rdchk(2'h0, 5'h00, 16'h1540);
      wr(2'h1, 5'h00, 16'h0020);
      chk_lvl(1, 1'b0, 1'b0, 1'b0, 1'b1);
      rdchk(2'h1, 5'h00, 16'h0160);
   endtask : t_store

   // restart pulse lasts one cycle and reads back clear
   task automatic t_pulse();
      wr(2'h2, 5'h00, 16'h1740);
      chk1("an_restart", 1'b1, chan_ctrl[2].an_restart);
      @(posedge sys_clk);
      #1;
      chk1("an_restart", 1'b0, chan_ctrl[2].an_restart);
      rdchk(2'h2, 5'h00, 16'h1540);
      wr(2'h2, 5'h00, 16'hC820);
      chk1("module_reset", 1'b1, chan_ctrl[2].module_reset);
      rdchk(2'h2, 5'h00, 16'h1540);
      rdchk(2'h1, 5'h00, 16'h0160);
   endtask : t_pulse

   // power-down holds against a write of 0, module reset clears it
   task automatic t_power();
      wr(2'h0, 5'h00, 16'h1D40);
      chk_lvl(0, 1'b1, 1'b1, 1'b1, 1'b0);
      wr(2'h0, 5'h00, 16'h1540);
      chk_lvl(0, 1'b1, 1'b1, 1'b1, 1'b0);
      rdchk(2'h0, 5'h00, 16'h1D40);
      wr(2'h0, 5'h00, 16'h8000);
      chk1("module_reset", 1'b1, chan_ctrl[0].module_reset);
      @(posedge sys_clk);
      #1;
      chk1("module_reset", 1'b0, chan_ctrl[0].module_reset);
      chk_lvl(0, 1'b1, 1'b1, 1'b0, 1'b0);
      rdchk(2'h0, 5'h00, 16'h1540);
   endtask : t_power

   // undefined addresses read zero and ignore writes
   task automatic t_unmapped();
      wr(2'h3, 5'h01, 16'h0A20);
      rdchk(2'h3, 5'h01, 16'h0000);
      rdchk(2'h3, 5'h1F, 16'h0000);
      rdchk(2'h3, 5'h00, 16'h1540);
      chk_lvl(3, 1'b1, 1'b1, 1'b0, 1'b0);
   endtask : t_unmapped

   // main sequence
   initial begin
      repeat (5) @(posedge sys_clk);
      #1;
      reset = 1'b0;
      t_defaults();
      t_store();
      t_pulse();
      t_power();
      t_unmapped();
      give_verdict();
   end
endmodule : sgmii_channel_control_reg_tb
